// file: logic/wiper_pkg.sv
// Constants and types shared by the dual wiper serial command unit
package wiper_pkg;

    localparam int POS_W = 5;
    localparam int TAPS = 32;
    localparam int NPINS = 5;

    // Wiper positions
    localparam logic [4:0] TAP_MUTE = 5'h00;
    localparam logic [4:0] TAP_TOP = 5'h1F;
    localparam logic [4:0] TAP_ONE = 5'h01;
    localparam logic [2:0] DATA_PAD = 3'h0;

    // Serial byte framing
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;
    localparam int MSB = 7;

    // Slave byte fields
    localparam int SLV_TYPE_HI = 7;
    localparam int SLV_TYPE_LO = 4;
    localparam int SLV_FIXED = 3;
    localparam int SLV_A1 = 2;
    localparam int SLV_A0 = 1;
    localparam int SLV_RW = 0;
    localparam logic ADDR_FIXED_BIT = 1'b0;

    // Command byte fields and opcodes
    localparam int CMD_OP_HI = 7;
    localparam int CMD_OP_LO = 4;
    localparam int CMD_ZD = 2;
    localparam int CMD_SEL_HI = 1;
    localparam int CMD_SEL_LO = 0;
    localparam logic [3:0] OP_WRITE = 4'hA;
    localparam logic [3:0] OP_STEP = 4'h2;
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEL_LEFT = 2'h1;
    localparam logic [1:0] SEL_RIGHT = 2'h2;
    localparam logic [1:0] SEL_BOTH = 2'h3;

    // Synchroniser reset levels: scl, sda idle high; detector and straps low
    localparam logic [4:0] SYNC_RESET = 5'h18;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h3,
        ST_CMD = 4'h2,
        ST_CMD_ACK = 4'h6,
        ST_WDATA = 4'h7,
        ST_WDATA_ACK = 4'h5,
        ST_STEP = 4'h4,
        ST_RDATA = 4'hC,
        ST_RACK = 4'hD
    } state_t;

    typedef struct packed {
        logic scl;
        logic sda;
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
        logic zero_cross;
        logic strap1;
        logic strap0;
    } line_t;

    typedef struct packed {
        state_t state;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic zd;
        logic [1:0] sel;
        logic second;
        logic sda_oe;
    } ctrl_t;

endpackage

// file: logic/line_sync.sv
// Pin synchroniser and bus condition detector
`timescale 1ns/1ns
`default_nettype none

module line_sync (
    input wire logic clk,
    input wire logic srst,
    input wire logic [4:0] pin_in,
    output wiper_pkg::line_t line
);

    logic [4:0] sync_vec;
    logic [4:0] prev_vec;

    // Bit order of pin_in: scl, sda, zero cross, strap1, strap0
    genvar i;
    generate
        for (i = 0; i < wiper_pkg::NPINS; i++) begin : g_bit
            logic meta_reg;
            logic sync_reg;
            logic prev_reg;
            always_ff @(posedge clk) begin
                if (srst) begin
                    meta_reg <= wiper_pkg::SYNC_RESET[i];
                    sync_reg <= wiper_pkg::SYNC_RESET[i];
                    prev_reg <= wiper_pkg::SYNC_RESET[i];
                end else begin
                    meta_reg <= pin_in[i];
                    sync_reg <= meta_reg;
                    prev_reg <= sync_reg;
                end
            end
            assign sync_vec[i] = sync_reg;
            assign prev_vec[i] = prev_reg;
        end
    endgenerate

    // Start and stop need scl high on both samples around the sda edge
    assign line.scl = sync_vec[4];
    assign line.sda = sync_vec[3];
    assign line.scl_rise = sync_vec[4] & ~prev_vec[4];
    assign line.scl_fall = ~sync_vec[4] & prev_vec[4];
    assign line.start = sync_vec[4] & prev_vec[4] & prev_vec[3] & ~sync_vec[3];
    assign line.stop = sync_vec[4] & prev_vec[4] & ~prev_vec[3] & sync_vec[3];
    assign line.zero_cross = sync_vec[2];
    assign line.strap1 = sync_vec[1];
    assign line.strap0 = sync_vec[0];

endmodule

`default_nettype wire

// file: logic/dual_wiper_serial_command_unit.sv
// Two-wire slave command logic holding the left and right wiper positions
`timescale 1ns/1ns
`default_nettype none

module dual_wiper_serial_command_unit #(
    // Arbitrary value, not tied to any real part
    parameter logic [3:0] DEVICE_TYPE = 4'h9
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic STRAP_ADDR1,
    input wire logic STRAP_ADDR0,
    input wire logic ZERO_CROSS_DET,
    output logic ZERO_CROSS_ENABLE,
    output logic [4:0] LEFT_WIPER_POS,
    output logic [4:0] RIGHT_WIPER_POS,
    output logic [31:0] LEFT_TAP_SEL,
    output logic [31:0] RIGHT_TAP_SEL
);

    // ------------------------------------------------------------
    // Pin synchronisers and protocol state
    // ------------------------------------------------------------
    wiper_pkg::line_t ln;

    line_sync u_sync (
        .clk(CLK),
        .srst(SRST),
        .pin_in({SCL, SDA_IN, ZERO_CROSS_DET, STRAP_ADDR1, STRAP_ADDR0}),
        .line(ln)
    );

    wiper_pkg::ctrl_t c_reg, c_next;
    logic [4:0] left_pos_reg, left_pos_next;
    logic [4:0] right_pos_reg, right_pos_next;
    logic addr_match, cmd_valid, byte_full, wr_left, wr_right;
    logic [7:0] tx_byte;

    function automatic logic [4:0] step_pos(input logic [4:0] p, input logic up);
        logic [4:0] r;
        r = p;
        if (up && p != wiper_pkg::TAP_TOP) begin
            r = p + wiper_pkg::TAP_ONE;
        end else if (!up && p != wiper_pkg::TAP_MUTE) begin
            r = p - wiper_pkg::TAP_ONE;
        end
        return r;
    endfunction

    assign byte_full = ln.scl_fall && c_reg.cnt == wiper_pkg::BYTE_BITS;
    // Type identifier is the master's duty; it is still checked here
    assign addr_match = c_reg.shift[wiper_pkg::SLV_TYPE_HI:wiper_pkg::SLV_TYPE_LO]
                        == DEVICE_TYPE
                        && c_reg.shift[wiper_pkg::SLV_FIXED] == wiper_pkg::ADDR_FIXED_BIT
                        && c_reg.shift[wiper_pkg::SLV_A1] == ln.strap1
                        && c_reg.shift[wiper_pkg::SLV_A0] == ln.strap0;
    // The don't-care bit is not checked; a zero channel select is refused
    assign cmd_valid = (c_reg.shift[wiper_pkg::CMD_OP_HI:wiper_pkg::CMD_OP_LO]
                        == wiper_pkg::OP_WRITE
                        || c_reg.shift[wiper_pkg::CMD_OP_HI:wiper_pkg::CMD_OP_LO]
                        == wiper_pkg::OP_STEP)
                       && c_reg.shift[wiper_pkg::CMD_SEL_HI:wiper_pkg::CMD_SEL_LO]
                       != wiper_pkg::SEL_NONE;
    // Both-channel writes take the left byte first, then the right
    assign wr_left = c_reg.sel == wiper_pkg::SEL_LEFT
                     || (c_reg.sel == wiper_pkg::SEL_BOTH && !c_reg.second);
    assign wr_right = c_reg.sel == wiper_pkg::SEL_RIGHT
                      || (c_reg.sel == wiper_pkg::SEL_BOTH && c_reg.second);
    assign tx_byte = c_reg.second ? {wiper_pkg::DATA_PAD, right_pos_reg}
                                  : {wiper_pkg::DATA_PAD, left_pos_reg};

    always_comb begin
        c_next = c_reg;
        left_pos_next = left_pos_reg;
        right_pos_next = right_pos_reg;
        if (ln.stop) begin
            c_next.state = wiper_pkg::ST_IDLE;
            c_next.sda_oe = 1'b0;
        end else if (ln.start) begin
            c_next.state = wiper_pkg::ST_ADDR;
            c_next.cnt = wiper_pkg::CNT_ZERO;
            c_next.second = 1'b0;
            c_next.sda_oe = 1'b0;
        end else begin
            case (c_reg.state)
                wiper_pkg::ST_ADDR, wiper_pkg::ST_CMD, wiper_pkg::ST_WDATA: begin
                    if (ln.scl_rise) begin
                        c_next.shift = {c_reg.shift[6:0], ln.sda};
                        c_next.cnt = c_reg.cnt + wiper_pkg::CNT_ONE;
                    end else if (byte_full) begin
                        c_next.cnt = wiper_pkg::CNT_ZERO;
                        c_next.sda_oe = 1'b1;
                        if (c_reg.state == wiper_pkg::ST_ADDR) begin
                            c_next.state = wiper_pkg::ST_ADDR_ACK;
                            if (!addr_match) begin
                                c_next.state = wiper_pkg::ST_IDLE;
                                c_next.sda_oe = 1'b0;
                            end
                        end else if (c_reg.state == wiper_pkg::ST_CMD) begin
                            c_next.state = wiper_pkg::ST_CMD_ACK;
                            if (!cmd_valid) begin
                                c_next.state = wiper_pkg::ST_IDLE;
                                c_next.sda_oe = 1'b0;
                            end else begin
                                c_next.zd = c_reg.shift[wiper_pkg::CMD_ZD];
                                c_next.sel = c_reg.shift[wiper_pkg::CMD_SEL_HI:
                                                         wiper_pkg::CMD_SEL_LO];
                            end
                        end else begin
                            c_next.state = wiper_pkg::ST_WDATA_ACK;
                            if (wr_left) begin
                                left_pos_next = c_reg.shift[4:0];
                            end
                            if (wr_right) begin
                                right_pos_next = c_reg.shift[4:0];
                            end
                        end
                    end
                end
                wiper_pkg::ST_ADDR_ACK: begin
                    if (ln.scl_fall) begin
                        if (c_reg.shift[wiper_pkg::SLV_RW]) begin
                            // Read needs no command byte
                            c_next.state = wiper_pkg::ST_RDATA;
                            c_next.shift = tx_byte;
                            c_next.sda_oe = ~tx_byte[wiper_pkg::MSB];
                        end else begin
                            c_next.state = wiper_pkg::ST_CMD;
                            c_next.sda_oe = 1'b0;
                        end
                    end
                end
                wiper_pkg::ST_CMD_ACK: begin
                    if (ln.scl_fall) begin
                        c_next.sda_oe = 1'b0;
                        c_next.state = c_reg.shift[wiper_pkg::CMD_OP_HI:wiper_pkg::CMD_OP_LO]
                                       == wiper_pkg::OP_STEP ? wiper_pkg::ST_STEP
                                                             : wiper_pkg::ST_WDATA;
                    end
                end
                wiper_pkg::ST_WDATA_ACK: begin
                    if (ln.scl_fall) begin
                        c_next.sda_oe = 1'b0;
                        c_next.state = wiper_pkg::ST_IDLE;
                        if (c_reg.sel == wiper_pkg::SEL_BOTH && !c_reg.second) begin
                            c_next.second = 1'b1;
                            c_next.state = wiper_pkg::ST_WDATA;
                        end
                    end
                end
                wiper_pkg::ST_STEP: begin
                    if (ln.scl_rise && c_reg.sel[wiper_pkg::CMD_SEL_LO]) begin
                        left_pos_next = step_pos(left_pos_reg, ln.sda);
                    end
                    if (ln.scl_rise && c_reg.sel[wiper_pkg::CMD_SEL_HI]) begin
                        right_pos_next = step_pos(right_pos_reg, ln.sda);
                    end
                end
                wiper_pkg::ST_RDATA: begin
                    if (ln.scl_rise) begin
                        c_next.cnt = c_reg.cnt + wiper_pkg::CNT_ONE;
                    end else if (byte_full) begin
                        c_next.sda_oe = 1'b0;
                        c_next.state = wiper_pkg::ST_RACK;
                    end else if (ln.scl_fall) begin
                        c_next.shift = {c_reg.shift[6:0], 1'b0};
                        c_next.sda_oe = ~c_reg.shift[6];
                    end
                end
                wiper_pkg::ST_RACK: begin
                    // A master nack, or the end of the right byte, ends the read
                    if (ln.scl_rise && (ln.sda || c_reg.second)) begin
                        c_next.state = wiper_pkg::ST_IDLE;
                    end else if (ln.scl_fall) begin
                        c_next.second = 1'b1;
                        c_next.cnt = wiper_pkg::CNT_ZERO;
                        c_next.state = wiper_pkg::ST_RDATA;
                        c_next.shift = {wiper_pkg::DATA_PAD, right_pos_reg};
                        c_next.sda_oe = ~wiper_pkg::DATA_PAD[2];
                    end
                end
                default: begin
                    c_next.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            c_reg <= '0;
            left_pos_reg <= wiper_pkg::TAP_MUTE;
            right_pos_reg <= wiper_pkg::TAP_MUTE;
        end else begin
            c_reg <= c_next;
            left_pos_reg <= left_pos_next;
            right_pos_reg <= right_pos_next;
        end
    end

    // ------------------------------------------------------------
    // Switch control
    // ------------------------------------------------------------
    // The registers update at once; only the tap switches wait for a zero crossing
    logic [4:0] left_applied_reg, left_applied_next;
    logic [4:0] right_applied_reg, right_applied_next;
    logic [31:0] left_tap_next, right_tap_next;
    logic [31:0] left_tap_reg, right_tap_reg;
    logic sda_out_reg;

    always_comb begin
        left_applied_next = left_applied_reg;
        right_applied_next = right_applied_reg;
        if (!c_reg.zd || ln.zero_cross) begin
            left_applied_next = left_pos_reg;
            right_applied_next = right_pos_reg;
        end
    end
    genvar t;
    generate
        for (t = 0; t < wiper_pkg::TAPS; t++) begin : g_tap
            assign left_tap_next[t] = left_applied_next == 5'(t);
            assign right_tap_next[t] = right_applied_next == 5'(t);
        end
    endgenerate

    always_ff @(posedge CLK) begin
        if (SRST) begin
            left_applied_reg <= wiper_pkg::TAP_MUTE;
            right_applied_reg <= wiper_pkg::TAP_MUTE;
            left_tap_reg <= 32'h00000001;
            right_tap_reg <= 32'h00000001;
            sda_out_reg <= 1'b0;
        end else begin
            left_applied_reg <= left_applied_next;
            right_applied_reg <= right_applied_next;
            left_tap_reg <= left_tap_next;
            right_tap_reg <= right_tap_next;
            sda_out_reg <= 1'b0;
        end
    end

    // Open drain: the pin is only ever pulled low
    assign SDA_OUT = sda_out_reg;
    assign SDA_OE = c_reg.sda_oe;
    assign ZERO_CROSS_ENABLE = c_reg.zd;
    assign LEFT_WIPER_POS = left_pos_reg;
    assign RIGHT_WIPER_POS = right_pos_reg;
    assign LEFT_TAP_SEL = left_tap_reg;
    assign RIGHT_TAP_SEL = right_tap_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    a_addr_ack: assert property (
        c_reg.state == wiper_pkg::ST_ADDR && byte_full && !ln.stop && !ln.start && addr_match
        |=> SDA_OE && c_reg.state == wiper_pkg::ST_ADDR_ACK)
        else $error("matching slave byte not acknowledged");
    a_addr_nack: assert property (
        c_reg.state == wiper_pkg::ST_ADDR && byte_full && !ln.stop && !ln.start && !addr_match
        |=> !SDA_OE && c_reg.state == wiper_pkg::ST_IDLE)
        else $error("foreign slave byte acknowledged");
    a_cmd_nack: assert property (
        c_reg.state == wiper_pkg::ST_CMD && byte_full && !ln.stop && !ln.start && !cmd_valid
        |=> !SDA_OE && c_reg.state == wiper_pkg::ST_IDLE)
        else $error("invalid command acknowledged");
    a_read_dir: assert property (
        c_reg.state == wiper_pkg::ST_ADDR_ACK && ln.scl_fall && !ln.stop
        |=> c_reg.state == ($past(c_reg.shift[0]) ? wiper_pkg::ST_RDATA : wiper_pkg::ST_CMD))
        else $error("direction bit not honoured");
    a_left_first: assert property (
        c_reg.state == wiper_pkg::ST_ADDR_ACK && ln.scl_fall && c_reg.shift[0] && !ln.stop
        |=> c_reg.shift == {wiper_pkg::DATA_PAD, $past(left_pos_reg)})
        else $error("read does not start with left wiper");
    a_write_load: assert property (
        c_reg.state == wiper_pkg::ST_WDATA && byte_full && wr_left && !ln.stop && !ln.start
        |=> left_pos_reg == $past(c_reg.shift[4:0]))
        else $error("left wiper not loaded by write");
    a_step_up: assert property (
        c_reg.state == wiper_pkg::ST_STEP && ln.scl_rise && ln.sda && !ln.stop && !ln.start
        && c_reg.sel[0] && left_pos_reg != wiper_pkg::TAP_TOP
        |=> left_pos_reg == $past(left_pos_reg) + wiper_pkg::TAP_ONE)
        else $error("left wiper did not step up");
    a_step_down: assert property (
        c_reg.state == wiper_pkg::ST_STEP && ln.scl_rise && !ln.sda && !ln.stop && !ln.start
        && c_reg.sel[1] && right_pos_reg != wiper_pkg::TAP_MUTE
        |=> right_pos_reg == $past(right_pos_reg) - wiper_pkg::TAP_ONE)
        else $error("right wiper did not step down");
    a_step_sat: assert property (
        c_reg.state == wiper_pkg::ST_STEP && right_pos_reg == wiper_pkg::TAP_TOP && ln.sda
        |=> right_pos_reg == wiper_pkg::TAP_TOP)
        else $error("right wiper wrapped past top tap");
    a_tap_onehot: assert property (
        ##1 $onehot(LEFT_TAP_SEL) && $onehot(RIGHT_TAP_SEL))
        else $error("tap select not one-hot");
    a_zero_wait: assert property (
        c_reg.zd && !ln.zero_cross |=> $stable(left_applied_reg) && $stable(right_applied_reg))
        else $error("switching did not wait for zero crossing");

    c_both_write: cover property (c_reg.state == wiper_pkg::ST_WDATA_ACK && c_reg.second);
    c_read_right: cover property (c_reg.state == wiper_pkg::ST_RDATA && c_reg.second);
    c_step_top: cover property (
        c_reg.state == wiper_pkg::ST_STEP && right_pos_reg == wiper_pkg::TAP_TOP);

endmodule

`default_nettype wire

// file: testbench/bus_master_model.sv
// Two-wire bus master model facing the serial side of the wiper unit
`timescale 1ns/1ns
`default_nettype none

module bus_master_model (
    input wire logic clk,
    input wire logic sda_oe,
    output logic scl,
    output logic sda_line
);
    logic sda_drv;

    // Pull-up on the wire: low when either side pulls it
    assign sda_line = sda_drv & ~sda_oe;

    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // -------------------------------------------------------------
    // Bus phases, changed on falling CLK edges only
    // -------------------------------------------------------------
    task automatic half();
        repeat (4) @(negedge clk);
    endtask

    task automatic start_cond();
        half();
        sda_drv = 1'b0;
        half();
        scl = 1'b0;
    endtask

    // Data moves mid-low so it never changes with SCL high
    task automatic bit_io(input logic b, output logic r);
        repeat (2) @(negedge clk);
        sda_drv = b;
        repeat (2) @(negedge clk);
        scl = 1'b1;
        half();
        r = sda_line;
        scl = 1'b0;
    endtask

    task automatic stop_cond();
        repeat (2) @(negedge clk);
        sda_drv = 1'b0;
        repeat (2) @(negedge clk);
        scl = 1'b1;
        half();
        sda_drv = 1'b1;
        half();
    endtask

    // Bytes go MSB first; the master releases the line for the ack
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    task automatic recv_byte(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~mack, r);
    endtask
endmodule

`default_nettype wire

// file: testbench/dual_wiper_serial_command_unit_tb.sv
// Self-checking testbench for the dual wiper serial command unit
`timescale 1ns/1ns
`default_nettype none

module dual_wiper_serial_command_unit_tb;
    // Arbitrary type value, unrelated to any real part
    localparam logic [3:0] TYPE_ID = 4'h9;
    localparam logic [7:0] SLV_W = {TYPE_ID, 4'h4};
    localparam logic [7:0] SLV_R = {TYPE_ID, 4'h5};
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic det = 1'b0;
    logic scl, sda, oe, zce, ack, sdo;
    logic s1 = 1'b1;
    logic s0 = 1'b0;
    logic [4:0] lpos, rpos;
    logic [31:0] ltap, rtap;
    logic [3:0] a;
    logic [7:0] rd;
    logic [15:0] bad [6] = '{16'h90A1, 16'h96A1, 16'h9CA1, 16'h34A1, 16'h9431, 16'h94A0};
    int bad_count = 0;
    int total_checks = 0;

    always #20 clk = ~clk;

    dual_wiper_serial_command_unit #(.DEVICE_TYPE(TYPE_ID)) u_dut (.CLK(clk), .SRST(srst),
        .SCL(scl), .SDA_IN(sda), .SDA_OUT(sdo), .SDA_OE(oe), .STRAP_ADDR1(s1),
        .STRAP_ADDR0(s0), .ZERO_CROSS_DET(det), .ZERO_CROSS_ENABLE(zce),
        .LEFT_WIPER_POS(lpos), .RIGHT_WIPER_POS(rpos), .LEFT_TAP_SEL(ltap),
        .RIGHT_TAP_SEL(rtap));

    bus_master_model u_master (.clk(clk), .sda_oe(oe), .scl(scl), .sda_line(sda));

    // -------------------------------------------------------------
    // Helpers and scenarios
    // -------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    // Sends n bytes from the top of the word, one ack bit per byte
    task automatic wr_seq(input logic [31:0] bytes, input int n);
        logic k;
        a = 4'h0;
        u_master.start_cond();
        for (int i = 0; i < n; i++) begin
            u_master.send_byte(bytes[31-8*i -: 8], k);
            a[i] = k;
        end
        u_master.stop_cond();
    endtask

    task automatic check_pos(input logic [4:0] l, input logic [4:0] r);
        check("left pos", 32'(lpos), 32'(l));
        check("right pos", 32'(rpos), 32'(r));
    endtask

    task automatic t_reset();
        check_pos(5'h00, 5'h00);
        check("left tap", ltap, 32'h1);
        check("zd", 32'(zce), 32'h0);
        check("right tap", rtap, 32'h1);
        check("oe idle", 32'(oe), 32'h0);
        check("sda out", 32'(sdo), 32'h0);
    endtask

    task automatic t_writes();
        wr_seq({SLV_W, 8'hA1, 8'h07, 8'h09}, 4);
        check("acks extra", 32'(a), 32'h7);
        check_pos(5'h07, 5'h00);
        check("left tap", ltap, 32'h1 << 7);
        wr_seq({SLV_W, 8'hA6, 8'h15, 8'h00}, 3);
        check("acks zd", 32'(a), 32'h7);
        check_pos(5'h07, 5'h15);
        check("zd on", 32'(zce), 32'h1);
        check("tap held", rtap, 32'h1);
        det = 1'b1;
        repeat (5) @(negedge clk);
        check("tap at zero", rtap, 32'h1 << 21);
        det = 1'b0;
        wr_seq({SLV_W, 8'hAB, 8'h03, 8'h1E}, 4);
        check("acks both", 32'(a), 32'hF);
        check_pos(5'h03, 5'h1E);
        check("zd off", 32'(zce), 32'h0);
    endtask

    task automatic t_read();
        u_master.start_cond();
        u_master.send_byte(SLV_R, ack);
        check("read ack", 32'(ack), 32'h1);
        u_master.recv_byte(1'b1, rd);
        check("left byte", 32'(rd), 32'h03);
        u_master.recv_byte(1'b0, rd);
        check("right byte", 32'(rd), 32'h1E);
        u_master.stop_cond();
        check("sda out read", 32'(sdo), 32'h0);
    endtask

    task automatic t_refuse();
        for (int i = 0; i < 6; i++) begin
            wr_seq({bad[i], 8'h1F, 8'h00}, 3);
            check("refused acks", 32'(a), (i < 4) ? 32'h0 : 32'h1);
        end
        check_pos(5'h03, 5'h1E);
        // Moved straps: the old address must be refused, the new one taken
        s1 = 1'b0;
        s0 = 1'b1;
        wr_seq({SLV_W, 8'hA2, 8'h1E, 8'h00}, 3);
        check("old strap acks", 32'(a), 32'h0);
        wr_seq({TYPE_ID, 4'h2, 8'hA2, 8'h1E, 8'h00}, 3);
        check("new strap acks", 32'(a), 32'h7);
        s1 = 1'b1;
        s0 = 1'b0;
    endtask

    task automatic t_step();
        u_master.start_cond();
        u_master.send_byte(SLV_W, ack);
        u_master.send_byte(8'h23, ack);
        check("step ack", 32'(ack), 32'h1);
        repeat (2) u_master.bit_io(1'b1, ack);
        check_pos(5'h05, 5'h1F);
        repeat (6) u_master.bit_io(1'b0, ack);
        check_pos(5'h00, 5'h19);
        // The SCL rise ahead of the stop carries SDA low, so it steps once more
        u_master.stop_cond();
        check_pos(5'h00, 5'h18);
        u_master.bit_io(1'b1, ack);
        check_pos(5'h00, 5'h18);
        // SCL is low here, so a stop first brings the bus back to idle
        u_master.stop_cond();
        u_master.start_cond();
        u_master.send_byte(SLV_W, ack);
        u_master.send_byte(8'h21, ack);
        check("left step ack", 32'(ack), 32'h1);
        repeat (2) u_master.bit_io(1'b1, ack);
        u_master.stop_cond();
        check_pos(5'h01, 5'h18);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end

    initial begin
        repeat (5) @(negedge clk);
        srst = 1'b0;
        repeat (3) @(negedge clk);
        t_reset();
        t_writes();
        t_read();
        t_refuse();
        t_step();
        report_and_stop();
    end
endmodule

`default_nettype wire
